//--- pkg/lsps_pkg.sv
package lsps_pkg;

   // Clock and timing
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned STAGE1_TIME_MS = 25;
   localparam int unsigned STAGE2_TIME_MS = 300;
   localparam int unsigned OC_FILTER_TIME_US = 300;
   localparam int unsigned TURNON_TIME_US = 1;
   localparam int unsigned NS_PER_MS = 1000000;
   localparam int unsigned NS_PER_US = 1000;
   // Least times, rounded up to whole cycles
   localparam int unsigned STAGE1_CYCLES =
      (STAGE1_TIME_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned STAGE2_CYCLES =
      (STAGE2_TIME_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned OC_FILTER_CYCLES =
      (OC_FILTER_TIME_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TURNON_CYCLES =
      (TURNON_TIME_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TIMER_W = 23;

   // Current thresholds, 1 A per code
   localparam logic [7:0] MAJOR_TRIP_AMPS = 8'hA0;
   localparam logic [7:0] LIMIT_STEP_AMPS = 8'h0B;
   localparam logic [3:0] ROTARY_MAX_POS = 4'h9;
   localparam logic [7:0] LIMIT_RESET = 8'h00;

   // Register port
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 8;
   localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] REG_LIMIT = 4'h1;
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'h2;
   localparam logic [ADDR_W-1:0] REG_ERRORS = 4'h3;
   localparam logic [ADDR_W-1:0] REG_ACTIVE_LIMIT = 4'h4;
   localparam int unsigned CTRL_ON_BIT = 0;
   localparam int unsigned CTRL_OFF_BIT = 1;
   localparam int unsigned CTRL_ACK_BIT = 2;

   // Synchronised pin vector layout
   localparam int unsigned PIN_ON_BTN = 0;
   localparam int unsigned PIN_OFF_BTN = 1;
   localparam int unsigned PIN_LIM_SEL = 2;
   localparam int unsigned PIN_VOUT10 = 3;
   localparam int unsigned PIN_VOUT85 = 4;
   localparam int unsigned PIN_ROT_LSB = 5;
   localparam int unsigned PIN_COUNT = 9;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_STAGE1 = 5'h02,
      ST_STAGE2 = 5'h04,
      ST_SETTLE = 5'h08,
      ST_ON = 5'h10
   } lsps_state_t;

   typedef struct packed {
      logic short_ckt;
      logic capacitance;
      logic overcurrent;
      logic major_overcurrent;
   } lsps_err_t;

   typedef struct packed {
      logic ready;
      logic preload;
      logic on;
      logic short_ckt;
      logic capacitance;
      logic overcurrent;
      logic major_overcurrent;
   } lsps_ind_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } lsps_bus_req_t;

endpackage

//--- logic/lsps_timer.sv
`timescale 1ns/1ps
module lsps_timer #(
   parameter int unsigned LIMIT = 1
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic run,
   output logic done
);
   import lsps_pkg::*;

   localparam logic [TIMER_W-1:0] LIMIT_V = LIMIT[TIMER_W-1:0];

   logic [TIMER_W-1:0] count;
   logic [TIMER_W-1:0] next_count;
   wire at_limit = (count == LIMIT_V);

   // Holds at the limit so done stays up until run drops
   assign next_count = !run ? '0 : (at_limit ? count : count + TIMER_W'(1));
   assign done = run & at_limit;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         count <= '0;
      else
         count <= next_count;
   end

endmodule

//--- logic/lsps_sequencer.sv
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
// Operation
// - After 25 ms check output above 10 %
// - Stage-one fail: abort, latch short error
// - Then at 300 ms check output 85 %
// - Stage-two fail: abort, latch capacitance error
// - Close mains only after both stages pass
// - Status high 1 us after gate on
// - Over limit beyond 300 us: trip, latch
// - Far over limit: trip at once, separate error
// - Major trip threshold fixed at 160 A
// - Any error disconnects, lights, reports remotely
// - Latched error blocks on until acknowledged
// - Panel or remote on treated alike
// - Panel or remote off opens switches
// - Rotary selects 0 to 99 A, 11 A steps
// - Remote limit in 1 A steps
// - Select input picks remote limit
// - Pre-load lamp exactly while resistor connected
// - On lamp while mains closed
// - Ready lamp once logic powered
// - No pre-charge for reverse flow
// - Any turn-off discharges gates under 1 us
module lsps_sequencer #(
   parameter int unsigned STAGE1_CYC = lsps_pkg::STAGE1_CYCLES,
   parameter int unsigned STAGE2_CYC = lsps_pkg::STAGE2_CYCLES,
   parameter int unsigned OC_FILTER_CYC = lsps_pkg::OC_FILTER_CYCLES
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic panel_on_btn,
   input wire logic panel_off_btn,
   input wire logic limit_source_select,
   input wire logic [3:0] rotary_pos,
   input wire logic vout_above_10pct,
   input wire logic vout_above_85pct,
   input wire logic [7:0] meas_current,
   input lsps_pkg::lsps_bus_req_t bus_req,
   output logic [lsps_pkg::DATA_W-1:0] rd_data,
   output logic precharge_gate,
   output logic main_gate,
   output logic main_switch_on,
   output logic [7:0] limit_amps,
   output lsps_pkg::lsps_ind_t indicators
);
   import lsps_pkg::*;

   // Pin synchronisers
   logic [PIN_COUNT-1:0] pins_raw;
   logic [PIN_COUNT-1:0] pins_meta;
   logic [PIN_COUNT-1:0] pins_sync;

   assign pins_raw[PIN_ON_BTN] = panel_on_btn;
   assign pins_raw[PIN_OFF_BTN] = panel_off_btn;
   assign pins_raw[PIN_LIM_SEL] = limit_source_select;
   assign pins_raw[PIN_VOUT10] = vout_above_10pct;
   assign pins_raw[PIN_VOUT85] = vout_above_85pct;
   assign pins_raw[PIN_ROT_LSB +: 4] = rotary_pos;

   genvar gi;
   generate
      for (gi = 0; gi < PIN_COUNT; gi++)
      begin : g_sync
         always_ff @(posedge ref_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               pins_meta[gi] <= 1'b0;
               pins_sync[gi] <= 1'b0;
            end
            else
            begin
               pins_meta[gi] <= pins_raw[gi];
               pins_sync[gi] <= pins_meta[gi];
            end
         end
      end
   endgenerate

   wire on_btn_lvl = pins_sync[PIN_ON_BTN];
   wire off_btn_lvl = pins_sync[PIN_OFF_BTN];
   wire lim_sel = pins_sync[PIN_LIM_SEL];
   wire vout10_ok = pins_sync[PIN_VOUT10];
   wire vout85_ok = pins_sync[PIN_VOUT85];
   wire [3:0] rot_sync = pins_sync[PIN_ROT_LSB +: 4];

   // Buttons act on the press edge so a held button does not retrigger
   logic on_btn_prev;
   logic off_btn_prev;
   wire on_btn_press = on_btn_lvl & ~on_btn_prev;
   wire off_btn_press = off_btn_lvl & ~off_btn_prev;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         on_btn_prev <= 1'b0;
         off_btn_prev <= 1'b0;
      end
      else
      begin
         on_btn_prev <= on_btn_lvl;
         off_btn_prev <= off_btn_lvl;
      end
   end

   // Register port decode
   wire wr_ctrl = bus_req.wr & (bus_req.addr == REG_CTRL);
   wire wr_limit = bus_req.wr & (bus_req.addr == REG_LIMIT);
   wire remote_on = wr_ctrl & bus_req.wdata[CTRL_ON_BIT];
   wire remote_off = wr_ctrl & bus_req.wdata[CTRL_OFF_BIT];
   wire remote_ack = wr_ctrl & bus_req.wdata[CTRL_ACK_BIT];

   wire req_on = on_btn_press | remote_on;
   wire req_off = off_btn_press | remote_off;
   wire err_clear = off_btn_press | remote_ack;

   // Current limit selection
   logic [7:0] remote_limit;
   logic [7:0] next_remote_limit;
   assign next_remote_limit = wr_limit ? bus_req.wdata : remote_limit;

   // Rotary bits are synchronised one by one, so a turn can show a mixed code
   // for a cycle; a code is taken only once it reads the same twice running.
   logic [3:0] rot_prev;
   logic [3:0] rot_held;
   logic [3:0] next_rot_held;
   assign next_rot_held = (rot_sync == rot_prev) ? rot_sync : rot_held;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rot_prev <= 4'h0;
         rot_held <= 4'h0;
      end
      else
      begin
         rot_prev <= rot_sync;
         rot_held <= next_rot_held;
      end
   end

   // A rotary code beyond the last detent saturates at the top step
   wire [3:0] rot_clamped = (rot_held > ROTARY_MAX_POS) ? ROTARY_MAX_POS : rot_held;
   wire [7:0] rot_pos8 = {4'h0, rot_clamped};
   wire [7:0] rotary_limit = 8'(rot_pos8 * LIMIT_STEP_AMPS);
   wire [7:0] active_limit = lim_sel ? remote_limit : rotary_limit;

   wire over_limit = meas_current > active_limit;
   wire major_trip = meas_current > MAJOR_TRIP_AMPS;

   // Sequencer
   lsps_state_t state;
   lsps_state_t next_state;
   lsps_err_t errors;
   lsps_err_t next_errors;
   lsps_err_t err_set;

   wire in_idle = (state == ST_IDLE);
   wire in_stage1 = (state == ST_STAGE1);
   wire in_stage2 = (state == ST_STAGE2);
   wire in_settle = (state == ST_SETTLE);
   wire in_on = (state == ST_ON);
   wire mains_driven = in_settle | in_on;
   wire any_err = |errors;

   logic stage1_done;
   logic stage2_done;
   logic settle_done;
   logic oc_done;

   // Stage-two timer counts from the start of pre-charge, not from stage two
   lsps_timer #(
      .LIMIT(STAGE1_CYC)
   ) u_stage1_timer (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .run(in_stage1),
      .done(stage1_done)
   );

   lsps_timer #(
      .LIMIT(STAGE2_CYC)
   ) u_stage2_timer (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .run(in_stage1 | in_stage2),
      .done(stage2_done)
   );

   lsps_timer #(
      .LIMIT(TURNON_CYCLES)
   ) u_settle_timer (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .run(in_settle),
      .done(settle_done)
   );

   // Any cycle at or under the limit restarts the persistence window
   lsps_timer #(
      .LIMIT(OC_FILTER_CYC)
   ) u_oc_filter (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .run(mains_driven & over_limit),
      .done(oc_done)
   );

   wire fault_trip = (~in_idle & major_trip) | (mains_driven & oc_done);

   always_comb
   begin
      next_state = state;
      case (state)
         ST_IDLE:
         begin
            // A trip already present refuses the start
            if (req_on && !any_err && !major_trip)
               next_state = ST_STAGE1;
         end
         ST_STAGE1:
         begin
            if (req_off || fault_trip)
               next_state = ST_IDLE;
            else if (stage1_done)
               next_state = vout10_ok ? ST_STAGE2 : ST_IDLE;
         end
         ST_STAGE2:
         begin
            if (req_off || fault_trip)
               next_state = ST_IDLE;
            else if (stage2_done)
               next_state = vout85_ok ? ST_SETTLE : ST_IDLE;
         end
         ST_SETTLE:
         begin
            if (req_off || fault_trip)
               next_state = ST_IDLE;
            else if (settle_done)
               next_state = ST_ON;
         end
         ST_ON:
         begin
            if (req_off || fault_trip)
               next_state = ST_IDLE;
         end
         default:
            next_state = ST_IDLE;
      endcase
   end

   // An off request in the deciding cycle wins and no check error is raised
   assign err_set.short_ckt = in_stage1 & stage1_done & ~vout10_ok & ~req_off
                              & ~fault_trip;
   assign err_set.capacitance = in_stage2 & stage2_done & ~vout85_ok & ~req_off
                                & ~fault_trip;
   assign err_set.overcurrent = mains_driven & oc_done;
   assign err_set.major_overcurrent = ~in_idle & major_trip;
   // A fault arriving with the acknowledge stays latched
   assign next_errors = err_set | (errors & ~{4{err_clear}});

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= ST_IDLE;
         errors <= '0;
         remote_limit <= LIMIT_RESET;
      end
      else
      begin
         state <= next_state;
         errors <= next_errors;
         remote_limit <= next_remote_limit;
      end
   end

   // Drive flops load from next_state so gates drop on the deciding edge,
   // one cycle, well inside the gate discharge budget.
   wire next_precharge = (next_state == ST_STAGE1) | (next_state == ST_STAGE2);
   wire next_main = (next_state == ST_SETTLE) | (next_state == ST_ON);
   wire next_main_on = (next_state == ST_ON);

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         precharge_gate <= 1'b0;
         main_gate <= 1'b0;
         main_switch_on <= 1'b0;
         limit_amps <= LIMIT_RESET;
      end
      else
      begin
         // Resistor path is forward only; nothing here serves reverse flow
         precharge_gate <= next_precharge;
         main_gate <= next_main;
         main_switch_on <= next_main_on;
         limit_amps <= active_limit;
      end
   end

   // Indicators
   logic ready_lamp;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         ready_lamp <= 1'b0;
      else
         ready_lamp <= 1'b1;
   end

   assign indicators.ready = ready_lamp;
   assign indicators.preload = precharge_gate;
   assign indicators.on = main_switch_on;
   assign indicators.short_ckt = errors.short_ckt;
   assign indicators.capacitance = errors.capacitance;
   assign indicators.overcurrent = errors.overcurrent;
   assign indicators.major_overcurrent = errors.major_overcurrent;

   // Register readback
   wire [DATA_W-1:0] status_word = {lim_sel, main_switch_on, precharge_gate, state};
   wire [DATA_W-1:0] errors_word = {4'h0, errors};
   logic [DATA_W-1:0] rd_sel;

   always_comb
   begin
      case (bus_req.addr)
         REG_LIMIT: rd_sel = remote_limit;
         REG_STATUS: rd_sel = status_word;
         REG_ERRORS: rd_sel = errors_word;
         REG_ACTIVE_LIMIT: rd_sel = active_limit;
         default: rd_sel = '0;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         rd_data <= '0;
      else
         rd_data <= bus_req.rd ? rd_sel : '0;
   end

endmodule

//--- bench/lsps_sequencer_props.sv
`timescale 1ns/1ps
module lsps_sequencer_props
   import lsps_pkg::*;
#(
   parameter int STAGE1_CYC = 20,
   parameter int STAGE2_CYC = 60,
   parameter int OC_FILTER_CYC = 10
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input lsps_pkg::lsps_bus_req_t bus_req,
   input wire logic [7:0] meas_current,
   input wire logic [7:0] rd_data,
   input wire logic precharge_gate,
   input wire logic main_gate,
   input wire logic main_switch_on,
   input wire logic [7:0] limit_amps,
   input lsps_pkg::lsps_ind_t indicators
);
   int pre_cnt;
   int oc_cnt;
   // Counters let the long pre-charge and filter times be checked without big repeats
   always_ff @(posedge ref_clk or negedge rst_n)
      if (!rst_n)
         pre_cnt <= 0;
      else
         pre_cnt <= precharge_gate ? pre_cnt + 1 : 0;
   always_ff @(posedge ref_clk or negedge rst_n)
      if (!rst_n)
         oc_cnt <= 0;
      else
         oc_cnt <= (main_gate && meas_current > limit_amps) ? oc_cnt + 1 : 0;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence s_gates_off;
      !precharge_gate && !main_gate && !main_switch_on;
   endsequence
   sequence s_remote_off;
      bus_req.wr && bus_req.addr == REG_CTRL && bus_req.wdata[CTRL_OFF_BIT];
   endsequence
   property p_pre_only;
      precharge_gate |-> !main_gate;
   endproperty
   property p_preload;
      indicators.preload == precharge_gate;
   endproperty
   property p_on_lamp;
      indicators.on == main_switch_on;
   endproperty
   property p_ready;
      $past(rst_n) |-> indicators.ready;
   endproperty
   property p_order;
      $rose(main_gate) |-> $past(precharge_gate) && pre_cnt >= STAGE2_CYC;
   endproperty
   property p_settle;
      $rose(main_switch_on) |-> $past(main_gate, 20);
   endproperty
   property p_short_time;
      $rose(indicators.short_ckt) |-> pre_cnt >= STAGE1_CYC && pre_cnt <= STAGE1_CYC + 2;
   endproperty
   property p_cap_time;
      $rose(indicators.capacitance) |-> pre_cnt >= STAGE2_CYC && pre_cnt <= STAGE2_CYC + 2;
   endproperty
   property p_oc_time;
      $rose(indicators.overcurrent) |-> oc_cnt >= OC_FILTER_CYC - 1 && oc_cnt <= OC_FILTER_CYC + 2;
   endproperty
   property p_major;
      meas_current > MAJOR_TRIP_AMPS && (precharge_gate || main_gate)
         |=> s_gates_off ##0 indicators.major_overcurrent;
   endproperty
   property p_blocked;
      $rose(precharge_gate) |-> $past(indicators[3:0]) == 4'h0;
   endproperty
   property p_off;
      s_remote_off |=> s_gates_off;
   endproperty
   property p_rd_idle;
      !bus_req.rd |=> rd_data == 8'h00;
   endproperty
   property p_limit_out;
      bus_req.rd && bus_req.addr == REG_ACTIVE_LIMIT |=> rd_data == limit_amps;
   endproperty
   property p_err_lamps;
      bus_req.rd && bus_req.addr == REG_ERRORS |=> rd_data[3:0] == $past(indicators[3:0]);
   endproperty
   a_pre_only: assert property (p_pre_only) else $error("main gate on with pre-charge");
   a_preload: assert property (p_preload) else $error("pre-load lamp wrong");
   a_on_lamp: assert property (p_on_lamp) else $error("on lamp wrong");
   a_ready: assert property (p_ready) else $error("ready lamp off");
   a_order: assert property (p_order) else $error("main gate early");
   a_settle: assert property (p_settle) else $error("status before settle");
   a_short_time: assert property (p_short_time) else $error("short check time");
   a_cap_time: assert property (p_cap_time) else $error("capacitance check time");
   a_oc_time: assert property (p_oc_time) else $error("over-current filter time");
   a_major: assert property (p_major) else $error("major trip missed");
   a_blocked: assert property (p_blocked) else $error("start with error latched");
   a_off: assert property (p_off) else $error("remote off ignored");
   a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");
   a_limit_out: assert property (p_limit_out) else $error("limit output differs");
   a_err_lamps: assert property (p_err_lamps) else $error("fault lamps differ");
endmodule
bind lsps_sequencer lsps_sequencer_props #(
   .STAGE1_CYC(STAGE1_CYC),
   .STAGE2_CYC(STAGE2_CYC),
   .OC_FILTER_CYC(OC_FILTER_CYC)
) lsps_sequencer_props_inst (
   .ref_clk(ref_clk),
   .rst_n(rst_n),
   .bus_req(bus_req),
   .meas_current(meas_current),
   .rd_data(rd_data),
   .precharge_gate(precharge_gate),
   .main_gate(main_gate),
   .main_switch_on(main_switch_on),
   .limit_amps(limit_amps),
   .indicators(indicators)
);

//--- bench/lsps_load_model.sv
`timescale 1ns/1ps
module lsps_load_model
(
   input wire logic ref_clk,
   input wire logic precharge_gate,
   input wire logic main_gate,
   input wire logic [1:0] load_kind,
   output logic vout_above_10pct,
   output logic vout_above_85pct
);
   // Kind 0 normal, 1 oversized capacitor that never reaches 85 %, 2 shorted output
   int charge = 0;
   always @(posedge ref_clk)
      charge <= (precharge_gate || main_gate) ? charge + 1 : 0;
   assign vout_above_10pct = (load_kind != 2'h2) && (charge > 5);
   assign vout_above_85pct = (load_kind == 2'h0) && (charge > 40);
endmodule

//--- bench/test_load_switch_precharge_sequencer.sv
`timescale 1ns/1ps
module test_load_switch_precharge_sequencer;
   import lsps_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic panel_on_btn = 1'b0;
   logic panel_off_btn = 1'b0;
   logic limit_source_select = 1'b0;
   logic [3:0] rotary_pos = 4'h0;
   logic [7:0] meas_current = 8'h00;
   logic [1:0] load_kind = 2'h0;
   lsps_bus_req_t bus_req = '0;
   logic [7:0] rd_data, limit_amps, lim;
   logic precharge_gate, main_gate, main_switch_on, vout10, vout85;
   lsps_ind_t indicators;
   logic rd_pend = 1'b0;
   logic [7:0] expq[$];
   int num_errors = 0;
   int n_compared = 0;
   int cycles = 0;
   lsps_sequencer #(.STAGE1_CYC(20), .STAGE2_CYC(60), .OC_FILTER_CYC(10)) lsps_sequencer_inst (
      .ref_clk(ref_clk), .rst_n(rst_n), .panel_on_btn(panel_on_btn),
      .panel_off_btn(panel_off_btn), .limit_source_select(limit_source_select),
      .rotary_pos(rotary_pos), .vout_above_10pct(vout10), .vout_above_85pct(vout85),
      .meas_current(meas_current), .bus_req(bus_req), .rd_data(rd_data),
      .precharge_gate(precharge_gate), .main_gate(main_gate),
      .main_switch_on(main_switch_on), .limit_amps(limit_amps), .indicators(indicators));
   lsps_load_model lsps_load_model_inst (
      .ref_clk(ref_clk), .precharge_gate(precharge_gate), .main_gate(main_gate),
      .load_kind(load_kind), .vout_above_10pct(vout10), .vout_above_85pct(vout85));
   initial
      forever #25 ref_clk = ~ref_clk;
   task automatic finish_test();
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      bus_req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      expq.push_back(exp);
      @(posedge ref_clk);
      bus_req.rd <= 1'b0;
   endtask
   task automatic expect_st(input logic [7:0] st, input logic [7:0] er);
      rd(REG_STATUS, st);
      rd(REG_ERRORS, er);
   endtask
   task automatic press(input logic off);
      @(posedge ref_clk);
      if (off)
         panel_off_btn <= 1'b1;
      else
         panel_on_btn <= 1'b1;
      repeat (4) @(posedge ref_clk);
      panel_off_btn <= 1'b0;
      panel_on_btn <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask
   always @(posedge ref_clk)
   begin
      if (rd_pend)
         chk(rd_data, expq.pop_front());
      rd_pend <= bus_req.rd;
      cycles++;
      // Whole run needs under 1500 cycles
      if (cycles > 4000)
      begin
         num_errors++;
         finish_test();
      end
   end
   initial
   begin
      void'($urandom(49));
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      expect_st(8'h01, 8'h00);
      rd(REG_LIMIT, LIMIT_RESET);
      wr(4'hF, 8'hFF);
      rd(4'hF, 8'h00);
      rd(REG_CTRL, 8'h00);
      for (int p = 0; p < 11; p++)
      begin
         rotary_pos <= (p == 10) ? 4'hC : 4'(p);
         repeat (5) @(posedge ref_clk);
         rd(REG_ACTIVE_LIMIT, (p == 10) ? 8'h63 : 8'(p) * LIMIT_STEP_AMPS);
      end
      lim = 8'($urandom_range(255, 0));
      wr(REG_LIMIT, lim);
      limit_source_select <= 1'b1;
      repeat (5) @(posedge ref_clk);
      rd(REG_ACTIVE_LIMIT, lim);
      limit_source_select <= 1'b0;
      repeat (5) @(posedge ref_clk);
      wr(REG_CTRL, 8'h01);
      rd(REG_STATUS, 8'h22);
      wr(REG_CTRL, 8'h01);
      repeat (100) @(posedge ref_clk);
      expect_st(8'h50, 8'h00);
      meas_current <= 8'h78;
      repeat (5) @(posedge ref_clk);
      meas_current <= 8'h00;
      repeat (20) @(posedge ref_clk);
      rd(REG_STATUS, 8'h50);
      meas_current <= 8'h64;
      repeat (20) @(posedge ref_clk);
      meas_current <= 8'h00;
      expect_st(8'h01, 8'h02);
      wr(REG_CTRL, 8'h01);
      rd(REG_STATUS, 8'h01);
      wr(REG_CTRL, 8'h04);
      rd(REG_ERRORS, 8'h00);
      load_kind <= 2'h2;
      press(1'b0);
      repeat (40) @(posedge ref_clk);
      expect_st(8'h01, 8'h08);
      press(1'b1);
      rd(REG_ERRORS, 8'h00);
      load_kind <= 2'h1;
      press(1'b0);
      repeat (80) @(posedge ref_clk);
      expect_st(8'h01, 8'h04);
      wr(REG_CTRL, 8'h04);
      load_kind <= 2'h0;
      wr(REG_CTRL, 8'h01);
      repeat (10) @(posedge ref_clk);
      meas_current <= MAJOR_TRIP_AMPS;
      repeat (3) @(posedge ref_clk);
      rd(REG_STATUS, 8'h22);
      meas_current <= MAJOR_TRIP_AMPS + 8'h01;
      repeat (3) @(posedge ref_clk);
      meas_current <= 8'h00;
      expect_st(8'h01, 8'h01);
      wr(REG_CTRL, 8'h04);
      wr(REG_CTRL, 8'h01);
      repeat (10) @(posedge ref_clk);
      wr(REG_CTRL, 8'h02);
      expect_st(8'h01, 8'h00);
      wr(REG_CTRL, 8'h01);
      repeat (100) @(posedge ref_clk);
      press(1'b1);
      expect_st(8'h01, 8'h00);
      finish_test();
   end
endmodule
